// [design/stamp_update_cfg.svh]
/*
  Constants of the stamp update unit: register offsets, field positions,
  reset values and timing counts.
  Assumes inclusion by bare name from the design files under design/.
*/
`ifndef STAMP_UPDATE_CFG_SVH
`define STAMP_UPDATE_CFG_SVH

`define CLK_PERIOD_NS   10
`define NS_PER_SEC      32'h3b9aca00
`define NS_STEP         (`CLK_PERIOD_NS)

`define REG_CTRL        8'h00
`define REG_FREQ        8'h04
`define REG_PPS_WIDTH   8'h08
`define REG_LOAD_SEC    8'h0c
`define REG_LOAD_NS     8'h10
`define REG_SAVE_SEC    8'h14
`define REG_SAVE_NS     8'h18
`define REG_RXCAP_SEC   8'h1c
`define REG_RXCAP_NS    8'h20
`define REG_FIFO_STAT   8'h24
`define REG_FIFO_SEC    8'h28
`define REG_FIFO_NS     8'h2c
`define REG_FIFO_ID     8'h30
`define REG_ENC_BASE    8'h40
`define REG_ENC_LAST    8'h57

`define CTRL_BYPASS     0
`define CTRL_SPLIT      1
`define CTRL_RX_BYPASS  2
`define CTRL_TX_BYPASS  3
`define CTRL_LOAD_MODE  4
`define CTRL_ADJ_UP     5
`define CTRL_ADJ_DOWN   6

`define ENC_KIND_OAM    16
`define ENC_ENABLE      17

`define CTRL_RESET      8'h01
`define PPS_WIDTH_RESET 32'h1dcd6500

`define SFD_BYTE        8'hd5
`define PTP_TYPE_LIMIT  4'h4
`define OAM_OP_1DM      8'h2d
`define OAM_OP_DMR      8'h2e
`define OAM_OP_DMM      8'h2f
`define ID_DELTA        8'h1e

`endif

// [design/stamp_update_pkg.sv]
/*
  Types of the stamp update unit.
  Assumes nothing of its surroundings.
*/
package stamp_update_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PRE  = 3'b010,
    ST_BODY = 3'b100
  } frame_state_t;
endpackage

// [design/stamp_update_unit.sv]
/*
  Stamp update unit: receive and transmit byte streams with frame
  detection, delay line, analyzer, rewriter, local time counter, pulse
  per second, load/save pin, egress stamp FIFO and an APB register slave.
  Assumes byte streams (enable + data) synchronous to clock_i and frames
  of at least 64 bytes after the start delimiter.
*/
// Behaviour
// - Unmatched frames pass unchanged, same length
// - Three configurable encapsulations recognised per channel
// - Receive frames stamped with ingress capture time
// - Transmit frames get time field rewritten
// - Both directions identical except egress FIFO
// - FIFO entry holds stamp and frame identifier
// - Each direction clocked by its datapath clock; here both run on clock_i
// - Load/save pin loads or saves time
// - Pulse per second with programmable width
// - Start detect feeds delay line and analyzer
// - Delay line outlasts analyzer decision time
// - Action chosen from mode and frame type
// - Capture time at start, readable by software
// - Optionally zero UDP checksum bytes
// - Recompute FCS after inserting time
// - Bypass changes only while idle
// - Split bypass uses per-direction controls
// - Pause frames pass unmodified
// - Act on Sync, Delay_req, Pdelay_req, Pdelay_resp
// - Software steps time by one nanosecond
// - Programmable clock count per 1 ns correction
// - Both analyzers share one configuration
// - Detect 1DM, DMM, DMR delay frames
// - No match gives no-modify action
`timescale 1ns/1ns
`include "stamp_update_cfg.svh"

module stamp_update_unit #(
  parameter int DELAY      = 64,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        rx_en_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_en_o,
  output logic      [7:0]  rx_data_o,
  input  wire logic        tx_en_i,
  input  wire logic [7:0]  tx_data_i,
  output logic             tx_en_o,
  output logic      [7:0]  tx_data_o,
  input  wire logic        load_save_i,
  output logic             pps_o
);

  localparam int NENC = 3;
  localparam int FW   = $clog2(FIFO_DEPTH);

  logic [7:0]  ctrl;
  logic [31:0] freq_cfg;
  logic [31:0] pps_width;
  logic [31:0] load_sec;
  logic [31:0] load_ns;
  logic [31:0] save_sec;
  logic [31:0] save_ns;
  logic [31:0] enc_a [NENC];
  logic [31:0] enc_b [NENC];
  logic [31:0] sec;
  logic [31:0] ns;
  logic [31:0] fcnt;
  logic        ls_meta;
  logic        ls_sync;
  logic        ls_prev;
  logic        adj_up;
  logic        adj_down;
  logic [63:0] cap [2];
  logic        in_en [2];
  logic [7:0]  in_d [2];
  logic        out_en [2];
  logic [7:0]  out_d [2];
  logic        fifo_push;
  logic [79:0] fifo_entry;
  logic [79:0] fifo_mem [FIFO_DEPTH];
  logic [FW-1:0] wr_ptr;
  logic [FW-1:0] rd_ptr;
  logic [FW:0]   fifo_cnt;
  logic        fifo_pop;
  logic        wr_acc;
  logic        setup;

  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ 32'hedb88320) : (r >> 1);
    end
    return r;
  endfunction

  assign in_en[0]  = rx_en_i;
  assign in_d[0]   = rx_data_i;
  assign in_en[1]  = tx_en_i;
  assign in_d[1]   = tx_data_i;
  assign rx_en_o   = out_en[0];
  assign rx_data_o = out_d[0];
  assign tx_en_o   = out_en[1];
  assign tx_data_o = out_d[1];

  // APB slave
  assign pready_o = 1'b1;
  assign setup    = psel_i && !penable_i;
  assign wr_acc   = psel_i && penable_i && pwrite_i;
  assign fifo_pop = psel_i && penable_i && !pwrite_i &&
                    paddr_i == `REG_FIFO_ID && fifo_cnt != '0;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl      <= `CTRL_RESET;
      freq_cfg  <= 32'h00000000;
      pps_width <= `PPS_WIDTH_RESET;
      load_sec  <= 32'h00000000;
      load_ns   <= 32'h00000000;
      for (int e = 0; e < NENC; e++) begin
        enc_a[e] <= 32'h00000000;
        enc_b[e] <= 32'h00000000;
      end
    end else if (wr_acc) begin
      case (paddr_i)
        `REG_CTRL:      ctrl      <= pwdata_i[7:0];
        `REG_FREQ:      freq_cfg  <= pwdata_i;
        `REG_PPS_WIDTH: pps_width <= pwdata_i;
        `REG_LOAD_SEC:  load_sec  <= pwdata_i;
        `REG_LOAD_NS:   load_ns   <= pwdata_i;
        default: begin
          for (int e = 0; e < NENC; e++) begin
            if (paddr_i == `REG_ENC_BASE + 8'(8 * e)) begin
              enc_a[e] <= pwdata_i;
            end
            if (paddr_i == `REG_ENC_BASE + 8'(8 * e + 4)) begin
              enc_b[e] <= pwdata_i;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      adj_up   <= 1'b0;
      adj_down <= 1'b0;
    end else begin
      adj_up   <= wr_acc && paddr_i == `REG_CTRL &&
                  pwdata_i[`CTRL_ADJ_UP];
      adj_down <= wr_acc && paddr_i == `REG_CTRL &&
                  pwdata_i[`CTRL_ADJ_DOWN];
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      pslverr_o <= 1'b0;
      case (paddr_i)
        `REG_CTRL:      prdata_o <= {24'h000000, ctrl};
        `REG_FREQ:      prdata_o <= freq_cfg;
        `REG_PPS_WIDTH: prdata_o <= pps_width;
        `REG_LOAD_SEC:  prdata_o <= load_sec;
        `REG_LOAD_NS:   prdata_o <= load_ns;
        `REG_SAVE_SEC:  prdata_o <= save_sec;
        `REG_SAVE_NS:   prdata_o <= save_ns;
        `REG_RXCAP_SEC: prdata_o <= cap[0][63:32];
        `REG_RXCAP_NS:  prdata_o <= cap[0][31:0];
        `REG_FIFO_STAT: prdata_o <= 32'(fifo_cnt);
        `REG_FIFO_SEC:  prdata_o <= fifo_mem[rd_ptr][79:48];
        `REG_FIFO_NS:   prdata_o <= fifo_mem[rd_ptr][47:16];
        `REG_FIFO_ID:   prdata_o <= {16'h0000, fifo_mem[rd_ptr][15:0]};
        default: begin
          prdata_o  <= 32'h00000000;
          pslverr_o <= 1'b1;
          for (int e = 0; e < NENC; e++) begin
            if (paddr_i == `REG_ENC_BASE + 8'(8 * e)) begin
              prdata_o  <= enc_a[e];
              pslverr_o <= 1'b0;
            end
            if (paddr_i == `REG_ENC_BASE + 8'(8 * e + 4)) begin
              prdata_o  <= enc_b[e];
              pslverr_o <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Load/save pin synchroniser
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ls_meta <= 1'b0;
      ls_sync <= 1'b0;
      ls_prev <= 1'b0;
    end else begin
      ls_meta <= load_save_i;
      ls_sync <= ls_meta;
      ls_prev <= ls_sync;
    end
  end

  // Local time counter
  logic        corr;
  logic [31:0] inc;
  logic [31:0] next_ns;
  assign corr = freq_cfg[30:0] != 31'h0 &&
                fcnt >= {1'b0, freq_cfg[30:0] - 31'h1};
  always_comb begin
    inc = 32'(`NS_STEP);
    if (adj_up) inc = inc + 32'h1;
    if (adj_down) inc = inc - 32'h1;
    if (corr) inc = freq_cfg[31] ? inc - 32'h1 : inc + 32'h1;
    next_ns = ns + inc;
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fcnt <= 32'h00000000;
    end else begin
      fcnt <= corr ? 32'h00000000 : fcnt + 32'h1;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sec <= 32'h00000000;
      ns  <= 32'h00000000;
    end else if (ls_sync && !ls_prev && ctrl[`CTRL_LOAD_MODE]) begin
      sec <= load_sec;
      ns  <= load_ns;
    end else if (next_ns >= `NS_PER_SEC) begin
      sec <= sec + 32'h1;
      ns  <= next_ns - `NS_PER_SEC;
    end else begin
      ns  <= next_ns;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      save_sec <= 32'h00000000;
      save_ns  <= 32'h00000000;
      pps_o    <= 1'b0;
    end else begin
      if (ls_sync && !ls_prev && !ctrl[`CTRL_LOAD_MODE]) begin
        save_sec <= sec;
        save_ns  <= ns;
      end
      pps_o <= ns < pps_width;
    end
  end

  // Egress stamp FIFO
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      fifo_cnt <= '0;
      for (int k = 0; k < FIFO_DEPTH; k++) begin
        fifo_mem[k] <= 80'h0;
      end
    end else begin
      if (fifo_push && fifo_cnt != (FW + 1)'(FIFO_DEPTH)) begin
        fifo_mem[wr_ptr] <= fifo_entry;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (fifo_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      fifo_cnt <= fifo_cnt
                + (FW + 1)'(fifo_push && fifo_cnt != (FW + 1)'(FIFO_DEPTH))
                - (FW + 1)'(fifo_pop);
    end
  end

  // Identical processors per direction; 0 is receive, 1 is transmit
  for (genvar g = 0; g < 2; g++) begin : dir
    logic [7:0] line_d [DELAY];
    logic       line_e [DELAY];
    stamp_update_pkg::frame_state_t st;
    stamp_update_pkg::frame_state_t ost;
    logic [15:0] pos;
    logic [15:0] opos;
    logic [NENC-1:0] hi_ok;
    logic [NENC-1:0] mt;
    logic [NENC-1:0] tk;
    logic [15:0] id;
    logic        hit;
    logic [1:0]  hit_idx;
    logic        act;
    logic [1:0]  sel;
    logic [63:0] stamp;
    logic [31:0] crc;
    logic        byp_e;
    logic [7:0]  byp_d;
    logic        beff;
    logic        want_byp;
    logic        line_busy;
    logic        fcs_zone;
    logic [1:0]  fcs_k;
    logic [7:0]  wr_byte;
    logic [15:0] soff;
    logic [15:0] coff;
    logic        sof;

    assign sof = st == stamp_update_pkg::ST_PRE && in_en[g] &&
                 in_d[g] == `SFD_BYTE;

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        for (int k = 0; k < DELAY; k++) begin
          line_d[k] <= 8'h00;
          line_e[k] <= 1'b0;
        end
      end else begin
        line_d[0] <= in_d[g];
        line_e[0] <= in_en[g];
        for (int k = 1; k < DELAY; k++) begin
          line_d[k] <= line_d[k-1];
          line_e[k] <= line_e[k-1];
        end
      end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        st  <= stamp_update_pkg::ST_IDLE;
        pos <= 16'h0000;
      end else begin
        case (st)
          stamp_update_pkg::ST_IDLE:
            if (in_en[g]) st <= stamp_update_pkg::ST_PRE;
          stamp_update_pkg::ST_PRE:
            if (!in_en[g]) begin
              st <= stamp_update_pkg::ST_IDLE;
            end else if (sof) begin
              st  <= stamp_update_pkg::ST_BODY;
              pos <= 16'h0000;
            end
          stamp_update_pkg::ST_BODY:
            if (!in_en[g]) st <= stamp_update_pkg::ST_IDLE;
            else pos <= pos + 16'h1;
          default: st <= stamp_update_pkg::ST_IDLE;
        endcase
      end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        cap[g] <= 64'h0;
      end else if (sof) begin
        cap[g] <= {sec, ns};
      end
    end

    // Analyzer: type match, message class, frame identifier
    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        hi_ok <= '0;
        mt    <= '0;
        tk    <= '0;
        id    <= 16'h0000;
      end else if (sof) begin
        mt <= '0;
        tk <= '0;
      end else if (st == stamp_update_pkg::ST_BODY && in_en[g]) begin
        for (int e = 0; e < NENC; e++) begin
          if (pos == {8'h00, enc_b[e][7:0]}) begin
            hi_ok[e] <= in_d[g] == enc_a[e][15:8];
          end
          if (pos == {8'h00, enc_b[e][7:0]} + 16'h1) begin
            mt[e] <= hi_ok[e] && in_d[g] == enc_a[e][7:0];
          end
          if (pos == {8'h00, enc_b[e][15:8]}) begin
            tk[e] <= enc_a[e][`ENC_KIND_OAM] ?
                     (in_d[g] == `OAM_OP_1DM || in_d[g] == `OAM_OP_DMM ||
                      in_d[g] == `OAM_OP_DMR) :
                     in_d[g][3:0] < `PTP_TYPE_LIMIT;
          end
        end
        if (pos == {8'h00, enc_b[hit_idx][15:8] + `ID_DELTA}) begin
          id[15:8] <= in_d[g];
        end
        if (pos == {8'h00, enc_b[hit_idx][15:8] + `ID_DELTA} + 16'h1) begin
          id[7:0] <= in_d[g];
        end
      end
    end

    // Lowest enabled encapsulation wins; none is a no-modify action
    always_comb begin
      hit     = 1'b0;
      hit_idx = 2'd0;
      for (int e = NENC - 1; e >= 0; e--) begin
        if (enc_a[e][`ENC_ENABLE] && mt[e] && tk[e]) begin
          hit     = 1'b1;
          hit_idx = 2'(e);
        end
      end
    end

    if (g == 1) begin : egress_fifo
      assign fifo_push = st == stamp_update_pkg::ST_BODY && in_en[g] &&
                         hit && pos == {8'h00, enc_b[hit_idx][15:8] +
                         `ID_DELTA} + 16'h2;
      assign fifo_entry = {cap[g], id};
    end

    // Rewriter at the delay line output
    assign soff = {8'h00, enc_b[sel][23:16]};
    assign coff = {8'h00, enc_b[sel][31:24]};
    assign fcs_zone = !line_e[DELAY-5];
    assign fcs_k = 2'd3 - 2'(32'(line_e[DELAY-2]) + 32'(line_e[DELAY-3]) +
                   32'(line_e[DELAY-4]));

    always_comb begin
      wr_byte = line_d[DELAY-1];
      if (ost == stamp_update_pkg::ST_BODY && act) begin
        if (opos >= soff && opos < soff + 16'h8) begin
          wr_byte = stamp[8'(63 - 8 * (opos - soff)) -: 8];
        end
        if (coff != 16'h0000 && (opos == coff || opos == coff + 16'h1)) begin
          wr_byte = 8'h00;
        end
        if (fcs_zone) begin
          wr_byte = ~crc[8 * fcs_k +: 8];
        end
      end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        ost   <= stamp_update_pkg::ST_IDLE;
        opos  <= 16'h0000;
        act   <= 1'b0;
        sel   <= 2'd0;
        stamp <= 64'h0;
        crc   <= 32'hffffffff;
      end else begin
        case (ost)
          stamp_update_pkg::ST_IDLE:
            if (line_e[DELAY-1]) ost <= stamp_update_pkg::ST_PRE;
          stamp_update_pkg::ST_PRE:
            if (!line_e[DELAY-1]) begin
              ost <= stamp_update_pkg::ST_IDLE;
            end else if (line_d[DELAY-1] == `SFD_BYTE) begin
              ost   <= stamp_update_pkg::ST_BODY;
              opos  <= 16'h0000;
              act   <= hit;
              sel   <= hit_idx;
              stamp <= cap[g];
              crc   <= 32'hffffffff;
            end
          stamp_update_pkg::ST_BODY:
            if (!line_e[DELAY-1]) begin
              ost <= stamp_update_pkg::ST_IDLE;
              act <= 1'b0;
            end else begin
              opos <= opos + 16'h1;
              if (!fcs_zone) crc <= crc_step(crc, wr_byte);
            end
          default: ost <= stamp_update_pkg::ST_IDLE;
        endcase
      end
    end

    // Bypass register and idle-gated switch
    always_comb begin
      line_busy = 1'b0;
      for (int k = 0; k < DELAY; k++) begin
        line_busy = line_busy | line_e[k];
      end
    end
    assign want_byp = ctrl[`CTRL_SPLIT] ?
                      ctrl[`CTRL_RX_BYPASS + g] : ctrl[`CTRL_BYPASS];

    always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
        byp_e     <= 1'b0;
        byp_d     <= 8'h00;
        beff      <= 1'b1;
        out_en[g] <= 1'b0;
        out_d[g]  <= 8'h00;
      end else begin
        byp_e <= in_en[g];
        byp_d <= in_d[g];
        if (!byp_e && !line_busy && !in_en[g]) beff <= want_byp;
        out_en[g] <= beff ? byp_e : line_e[DELAY-1];
        out_d[g]  <= beff ? byp_d : wr_byte;
      end
    end
  end

endmodule

// [dv/stream_partner.sv]
/*
  Byte stream partner: sends framed bytes and collects the returned stream.
  Assumes the block's stream ports run on clock_i, one byte per cycle.
*/
`timescale 1ns/1ns

module stream_partner (
  input  wire logic       clock_i,
  output logic            en_o,
  output logic [7:0]      data_o,
  input  wire logic       en_i,
  input  wire logic [7:0] data_i
);
  logic [7:0] got[$];
  int         cyc = 0;
  int         start = 0;
  int         lat = 0;
  logic       prev_o = 1'b0;
  logic       prev_i = 1'b0;

  initial begin
    en_o = 1'b0;
    data_o = 8'h00;
  end

  // Collects output bytes and the cycles from first byte in to first out
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (en_o && !prev_o) start = cyc;
    if (en_i && !prev_i) lat = cyc - start;
    if (en_i) got.push_back(data_i);
    prev_o = en_o;
    prev_i = en_i;
  end

  // Seven preamble bytes, delimiter, frame, then idle gap
  task automatic send(input logic [7:0] f[$]);
    for (int i = 0; i < 8 + f.size(); i++) begin
      @(posedge clock_i);
      en_o   <= 1'b1;
      data_o <= (i < 7) ? 8'h55 : (i == 7) ? 8'hd5 : f[i - 8];
    end
    @(posedge clock_i);
    en_o   <= 1'b0;
    data_o <= ~data_o;
    repeat (12) @(posedge clock_i);
  endtask
endmodule

// [dv/stamp_update_monitor.sv]
/*
  Checker of the stamp update unit port behaviour.
  Assumes binding to stamp_update_unit with its DELAY parameter.
*/
`timescale 1ns/1ns
`include "stamp_update_cfg.svh"

module stamp_update_monitor #(
  parameter int DELAY = 64
) (
  input wire logic       clock_i,
  input wire logic       rst_i,
  input wire logic       psel_i,
  input wire logic       penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic       pready_o,
  input wire logic       pslverr_o,
  input wire logic       rx_en_i,
  input wire logic       rx_en_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       tx_en_i,
  input wire logic       tx_en_o,
  input wire logic [7:0] tx_data_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_rx_head;
    (rx_data_o == 8'h55) [*7] ##1 (rx_data_o == `SFD_BYTE);
  endsequence
  sequence s_tx_head;
    (tx_data_o == 8'h55) [*7] ##1 (tx_data_o == `SFD_BYTE);
  endsequence

  property p_rise(logic o, logic i);
    $rose(o) |-> ($past(i, 2) && !$past(i, 3)) ||
                 ($past(i, DELAY + 1) && !$past(i, DELAY + 2));
  endproperty
  property p_fall(logic o, logic i);
    $fell(o) |-> (!$past(i, 2) && $past(i, 3)) ||
                 (!$past(i, DELAY + 1) && $past(i, DELAY + 2));
  endproperty

  AST_RX_HEAD: assert property ($rose(rx_en_o) |-> s_rx_head)
    else $error("rx output frame lacks preamble");
  AST_TX_HEAD: assert property ($rose(tx_en_o) |-> s_tx_head)
    else $error("tx output frame lacks preamble");
  AST_RX_RISE: assert property (p_rise(rx_en_o, rx_en_i))
    else $error("rx frame start latency wrong");
  AST_TX_RISE: assert property (p_rise(tx_en_o, tx_en_i))
    else $error("tx frame start latency wrong");
  AST_RX_FALL: assert property (p_fall(rx_en_o, rx_en_i))
    else $error("rx frame length changed");
  AST_TX_FALL: assert property (p_fall(tx_en_o, tx_en_i))
    else $error("tx frame length changed");
  AST_PREADY: assert property (psel_i && penable_i |-> pready_o)
    else $error("access phase without ready");
  AST_SLVERR: assert property (psel_i && !penable_i &&
    paddr_i[1:0] == 2'h0 && paddr_i <= `REG_FIFO_ID |=> !pslverr_o)
    else $error("error on mapped address");
endmodule

bind stamp_update_unit stamp_update_monitor #(.DELAY(DELAY))
  stamp_update_monitor_i (
  .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel_i),
  .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .rx_en_i(rx_en_i), .rx_en_o(rx_en_o),
  .rx_data_o(rx_data_o), .tx_en_i(tx_en_i), .tx_en_o(tx_en_o),
  .tx_data_o(tx_data_o));

// [dv/tb.sv]
/*
  Testbench of the stamp update unit: registers over APB, frames in both
  directions, bypass modes, egress stamp FIFO, load/save and pps.
  Assumes stream_partner and the design files under design/.
*/
`timescale 1ns/1ns
`include "stamp_update_cfg.svh"
`define CHECK(what, exp, seen) begin compares++; if ((seen) !== (exp)) \
  begin err_count++; $display("wrong value %s expected %h seen %h", \
  what, exp, seen); end end

module tb;
  typedef logic [7:0] bytes_t[$];
  localparam int DELAY = 64;
  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_en;
  logic [7:0]  rx_data;
  logic        rx_en_out;
  logic [7:0]  rx_data_out;
  logic        tx_en;
  logic [7:0]  tx_data;
  logic        tx_en_out;
  logic [7:0]  tx_data_out;
  logic        load_save = 1'b0;
  logic        pps;
  logic [63:0] stamp;
  int          err_count = 0;
  int          compares = 0;

  always #5 clock_i = ~clock_i;

  stamp_update_unit #(.DELAY(DELAY), .FIFO_DEPTH(8)) stamp_update_unit_i (
    .clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx_en_i(rx_en), .rx_data_i(rx_data),
    .rx_en_o(rx_en_out), .rx_data_o(rx_data_out), .tx_en_i(tx_en),
    .tx_data_i(tx_data), .tx_en_o(tx_en_out), .tx_data_o(tx_data_out),
    .load_save_i(load_save), .pps_o(pps));
  stream_partner rx_side_i (.clock_i(clock_i), .en_o(rx_en),
    .data_o(rx_data), .en_i(rx_en_out), .data_i(rx_data_out));
  stream_partner tx_side_i (.clock_i(clock_i), .en_o(tx_en),
    .data_o(tx_data), .en_i(tx_en_out), .data_i(tx_data_out));

  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic apb(input logic dir, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat,
                     output logic err);
    int n;
    n = 0;
    @(posedge clock_i);
    psel   <= 1'b1;
    pwrite <= dir;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      err_count++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask

  function automatic void fcs(inout bytes_t f);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 60; i++) begin
      c = c ^ {24'h0, f[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    for (int i = 0; i < 4; i++) f[60 + i] = ~c[8 * i +: 8];
  endfunction

  // Frame with match word at 12, message at 14, stamp at 22, id at 44
  function automatic bytes_t mk(input logic [15:0] m, input logic [7:0] msg,
                                input logic [7:0] id);
    bytes_t f;
    for (int i = 0; i < 64; i++)
      f.push_back((i > 21 && i < 30) ? 8'h00 : 8'(i));
    f[12] = m[15:8];
    f[13] = m[7:0];
    f[14] = msg;
    f[44] = id;
    fcs(f);
    return f;
  endfunction

  task automatic xfer(input logic dir, input bytes_t f, input logic md,
                      input int lat_exp);
    bytes_t g;
    bytes_t e;
    int     n;
    n = 0;
    e = f;
    if (dir) tx_side_i.send(f);
    else rx_side_i.send(f);
    do begin
      @(posedge clock_i);
      n++;
      g = dir ? tx_side_i.got : rx_side_i.got;
    end while (g.size() < 72 && n < 300);
    if (n == 300) begin
      err_count++;
      wrap_up();
    end
    repeat (3) @(posedge clock_i);
    g = dir ? tx_side_i.got : rx_side_i.got;
    `CHECK("length", 72, g.size())
    if (md) begin
      for (int i = 22; i < 30; i++) e[i] = g[i + 8];
      e[16] = 8'h00;
      e[17] = 8'h00;
      fcs(e);
    end
    for (int i = 0; i < 8; i++)
      `CHECK("preamble", i == 7 ? `SFD_BYTE : 8'h55, g[i])
    for (int i = 0; i < 64; i++)
      `CHECK("frame byte", e[i], g[i + 8])
    for (int i = 30; i < 38; i++) stamp = {stamp[55:0], g[i]};
    `CHECK("latency", lat_exp, dir ? tx_side_i.lat : rx_side_i.lat)
    if (dir) tx_side_i.got.delete();
    else rx_side_i.got.delete();
  endtask

  task automatic pulse();
    @(posedge clock_i);
    load_save <= 1'b1;
    repeat (4) @(posedge clock_i);
    load_save <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  initial begin
    logic [31:0] r;
    logic [31:0] s;
    logic        e;
    logic        md;
    logic [63:0] st[$];
    logic [7:0]  ids[$];
    repeat (16) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(`REG_CTRL, r);
    `CHECK("ctrl reset", {24'h0, `CTRL_RESET}, r)
    rd(`REG_PPS_WIDTH, r);
    `CHECK("pps width reset", `PPS_WIDTH_RESET, r)
    apb(1'b0, 8'h38, 32'h0, r, e);
    `CHECK("unmapped error", 1'b1, e)
    `CHECK("unmapped data", 32'h0, r)
    xfer(1'b0, mk(16'h88f7, 8'h00, 8'h00), 1'b0, 2);
    xfer(1'b1, mk(16'h88f7, 8'h00, 8'h00), 1'b0, 2);
    wr(`REG_ENC_BASE, 32'h000288f7);
    wr(`REG_ENC_BASE + 8'h04, 32'h10160e0c);
    wr(`REG_ENC_BASE + 8'h08, 32'h00038902);
    wr(`REG_ENC_BASE + 8'h0c, 32'h10160e0c);
    wr(`REG_CTRL, 32'h0);
    xfer(1'b0, mk(16'h88f7, 8'h01, 8'h09), 1'b1, DELAY + 1);
    rd(`REG_RXCAP_SEC, r);
    rd(`REG_RXCAP_NS, s);
    `CHECK("rx stamp", {r, s}, stamp)
    xfer(1'b0, mk(16'h1234, 8'h00, 8'h00), 1'b0, DELAY + 1);
    for (int k = 0; k < 9; k++) begin
      md = (k < 4) || (k > 4 && k < 8);
      xfer(1'b1, mk(k < 5 ? 16'h88f7 : 16'h8902, 8'(k < 5 ? k : k + 40),
           8'(k)), md, DELAY + 1);
      if (md) st.push_back(stamp);
      if (md) ids.push_back(8'(k));
    end
    rd(`REG_FIFO_STAT, r);
    `CHECK("fifo count", 32'h7, r)
    foreach (st[j]) begin
      rd(`REG_FIFO_SEC, r);
      rd(`REG_FIFO_NS, s);
      `CHECK("fifo stamp", st[j], {r, s})
      rd(`REG_FIFO_ID, r);
      `CHECK("fifo id", {16'h0, ids[j], 8'h2d}, r)
    end
    rd(`REG_FIFO_STAT, r);
    `CHECK("fifo empty", 32'h0, r)
    wr(`REG_CTRL, 32'h6);
    xfer(1'b0, mk(16'h1234, 8'h00, 8'h00), 1'b0, 2);
    xfer(1'b1, mk(16'h1234, 8'h00, 8'h00), 1'b0, DELAY + 1);
    wr(`REG_FREQ, 32'h1);
    wr(`REG_PPS_WIDTH, 32'h64);
    wr(`REG_LOAD_SEC, 32'h12);
    wr(`REG_LOAD_NS, 32'h0);
    wr(`REG_CTRL, 32'h10);
    pulse();
    `CHECK("pps high", 1'b1, pps)
    repeat (30) @(posedge clock_i);
    `CHECK("pps low", 1'b0, pps)
    wr(`REG_CTRL, 32'h20);
    pulse();
    rd(`REG_SAVE_SEC, r);
    `CHECK("saved sec", 32'h12, r)
    rd(`REG_SAVE_NS, r);
    `CHECK("saved ns step", 32'h1, r % 11)
    wrap_up();
  end
endmodule
